/* dv/scs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_asserts
    import scs_pkg::*;
(
    // Clock, reset and hard reset requests
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            sys_reset_pulse,
    input wire logic            wdt_reset_pulse,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic [7:0]      paddr,
    input wire logic            pslverr,
    // Oscillators and derived ticks
    input wire logic [NOSC-1:0] osc_tick,
    input wire logic [NOSC-1:0] osc_enable,
    input wire logic            root_core_clock,
    input wire logic            hclk_tick,
    input wire logic            pclk_tick,
    input wire logic            always_on_domain_clock,
    input wire logic            uart_baud_tick
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Hard reset request of either kind
    sequence s_hard;
        sys_reset_pulse || wdt_reset_pulse;
    endsequence
    // Access phase; only mapped aligned words are accepted
    sequence s_acc;
        psel && penable;
    endsequence
    property p_err; s_acc |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("pslverr does not match address");
    property p_inro; osc_enable[OSC_INRO]; endproperty
    a_inro: assert property (p_inro) else $error("nanoring enable low");
    property p_hclk; hclk_tick == root_core_clock; endproperty
    a_hclk: assert property (p_hclk) else $error("bus tick differs from root");
    // Peripheral tick is at most every second cycle, since it halves the root
    property p_pclk; pclk_tick |=> !pclk_tick; endproperty
    a_pclk: assert property (p_pclk) else $error("peripheral tick too close");
    // Four peripheral ticks at least, each two cycles apart
    property p_aon; always_on_domain_clock |=> !always_on_domain_clock [*7]; endproperty
    a_aon: assert property (p_aon) else $error("always-on tick too close");
    property p_baud; uart_baud_tick |-> $past(osc_tick[OSC_IBRO]); endproperty
    a_baud: assert property (p_baud) else $error("baud tick without source");
    property p_keep; s_hard |=> osc_enable[OSC_ERTCO] == $past(osc_enable[OSC_ERTCO]); endproperty
    a_keep: assert property (p_keep) else $error("crystal enable changed");
    property p_hard; s_hard |=> !osc_enable[OSC_ERFO] && osc_enable[OSC_IPO]; endproperty
    a_hard: assert property (p_hard) else $error("enables not restored");
endmodule // scs_asserts
`default_nettype wire

/* dv/scs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, sv, xv) begin samples_checked++; if ((sv) !== (xv)) begin n_mismatch++; \
    $display("mismatch %s exp %0h got %0h", nm, xv, sv); end end
module system_clock_switch_and_prescaler_tb_top;
    import scs_pkg::*;
    // Stimulus and observed ports
    logic                   pclk = 1'b0;
    logic                   presetn, sys_reset_pulse, wdt_reset_pulse, psel, penable, pwrite;
    logic [7:0]             paddr;
    logic [31:0]            pwdata, prdata, q;
    logic                   pready, pslverr, e, baud_osc_supply_select, root_core_clock;
    logic                   hclk_tick, pclk_tick, always_on_domain_clock, uart_baud_tick;
    logic [NOSC-1:0]        osc_tick, osc_ready_in, osc_enable;
    logic [TRIM_W-1:0]      ipo_trim;
    int                     n_mismatch = 0, samples_checked = 0, g, k;
    always #2.5 pclk = ~pclk;
    scs_clock_switch dut (.pclk, .presetn, .sys_reset_pulse, .wdt_reset_pulse, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_tick, .osc_ready_in,
        .osc_enable, .ipo_trim, .baud_osc_supply_select, .root_core_clock, .hclk_tick,
        .pclk_tick, .always_on_domain_clock, .uart_baud_tick);
    task give_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One APB transfer; entered just after a rising edge, ends one idle cycle later
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_mismatch++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Nothing is clocked from the ticks here, so no peripheral needs stopping
    task wcc(input logic [2:0] dv, input logic [2:0] sl, input logic [4:0] en, input logic vs);
        apb(1'b1, OFS_CLKCTRL, {10'h000, vs, en, 4'h0, sl, dv, 6'h00});
    endtask
    // Reads at least once, since a write leaves stale read data in q; bounded
    task poll();
        int i;
        i = 0;
        do begin
            apb(1'b0, OFS_CLKCTRL, 32'h0);
            i++;
        end while (q[CC_RDY_BIT] !== 1'b1 && i < 30);
        if (q[CC_RDY_BIT] !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    function automatic logic hit(input int s);
        return s == 0 ? root_core_clock : s == 1 ? pclk_tick : always_on_domain_clock;
    endfunction
    // Cycles between the second and third pulse, so a transition period is skipped
    task gap(input int s);
        for (int j = 0; j < 3; j++) begin
            g = 0;
            do begin
                @(negedge pclk);
                g++;
            end while (hit(s) !== 1'b1 && g < 1500);
            if (g >= 1500) begin
                n_mismatch++;
                give_verdict();
            end
        end
        @(posedge pclk);
    endtask
    task t_reset();
        apb(1'b0, OFS_CALCTRL, 32'h0);
        `CHK("calctrl", q[15:0], 16'h0040)
        apb(1'b0, OFS_CALINIT, 32'h0);
        `CHK("calinit", q, 32'h0000_0100)
        apb(1'b0, OFS_CALTIMING, 32'h0);
        `CHK("caltiming", q, 32'h000A_0BEB)
        apb(1'b0, OFS_BUSDIV, 32'h0);
        `CHK("busdiv", q, 32'h0)
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", {e, q}, 33'h1_0000_0000)
        `CHK("trim", ipo_trim, 9'h100)
        repeat (8) @(posedge pclk);
        apb(1'b0, OFS_CLKCTRL, 32'h0);
        `CHK("clkctrl", q, 32'h1616_2840)
    endtask
    task t_div();
        wcc(3'h3, SEL_IPO, 5'h16, 1'b0);
        gap(0);
        `CHK("root8", g, 8)
        gap(1);
        `CHK("pclk16", g, 16)
        apb(1'b1, OFS_BUSDIV, 32'h2);
        gap(2);
        `CHK("aon", g, 256)
        wcc(3'h7, SEL_IPO, 5'h16, 1'b0);
        gap(0);
        `CHK("root128", g, 128)
        wcc(3'h0, SEL_IPO, 5'h16, 1'b0);
        gap(0);
        `CHK("root1", g, 1)
    endtask
    // RF crystal loses ready while disabled and is then enabled, then regains it before it is selected
    task t_switch();
        osc_ready_in <= 5'h1E;
        wcc(3'h0, 3'h7, 5'h17, 1'b1);
        repeat (4) apb(1'b0, OFS_CLKCTRL, 32'h0);
        `CHK("done_bad", q[CC_RDY_BIT], 1'b0)
        `CHK("erfo_wait", q[CC_OK_LSB + OSC_ERFO], 1'b0)
        `CHK("supply", {q[CC_VS_BIT], baud_osc_supply_select}, 2'h3)
        osc_ready_in <= 5'h1F;
        repeat (3) apb(1'b0, OFS_CLKCTRL, 32'h0);
        `CHK("erfo_rdy", q[CC_OK_LSB + OSC_ERFO], 1'b1)
        wcc(3'h0, SEL_ERFO, 5'h17, 1'b1);
        poll();
        `CHK("erfo", {q[CC_RDY_BIT], q[24], q[11:9]}, 5'h1A)
        wcc(3'h0, SEL_ERTCO, 5'h17, 1'b1);
        repeat (4) apb(1'b0, OFS_CLKCTRL, 32'h0);
        `CHK("ertco_off", q[CC_RDY_BIT], 1'b0)
        wcc(3'h0, SEL_ERTCO, 5'h1F, 1'b1);
        poll();
        `CHK("ertco", {q[CC_RDY_BIT], q[11:9]}, 4'hE)
        wcc(3'h0, SEL_IPO, 5'h1F, 1'b0);
        poll();
        `CHK("ipo", {q[CC_RDY_BIT], q[11:9]}, 4'hC)
    endtask
    // Crystal is enabled and ready from the switch scenario; slow loop walks trim up
    task t_cal();
        apb(1'b1, OFS_CALTIMING, 32'h000A_0BEB);
        apb(1'b1, OFS_CALINIT, 32'h0000_0100);
        apb(1'b1, OFS_CALCTRL, 32'h0000_0040);
        apb(1'b0, OFS_CALCTRL, 32'h0);
        apb(1'b1, OFS_CALCTRL, q | 32'h7);
        repeat (700) @(posedge pclk);
        `CHK("trim_up", ipo_trim, 9'h1FF)
        apb(1'b1, OFS_CALCTRL, 32'h0000_0041);
        apb(1'b0, OFS_CALCTRL, 32'h0);
        `CHK("trim_keep", {q[24:16], ipo_trim}, 18'h3FFFF)
        apb(1'b1, OFS_CALCTRL, 32'h0000_0040);
        `CHK("trim_off", ipo_trim, 9'h100)
        // Undivided fast clock against a crystal at half rate walks trim down to zero
        apb(1'b1, OFS_CALTIMING, 32'h000A_0001);
        apb(1'b1, OFS_CALCTRL, 32'h0000_0047);
        repeat (1400) begin
            @(posedge pclk);
            osc_tick[OSC_ERTCO] <= ~osc_tick[OSC_ERTCO];
        end
        `CHK("trim_down", ipo_trim, 9'h000)
        apb(1'b1, OFS_CALCTRL, 32'h0000_0041);
    endtask
    // System then watchdog request; crystal enable must survive both
    task t_hard();
        for (k = 0; k < 2; k++) begin
            wcc(3'h0, SEL_IPO, 5'h1F, 1'b0);
            sys_reset_pulse <= (k == 0);
            wdt_reset_pulse <= (k == 1);
            @(posedge pclk);
            sys_reset_pulse <= 1'b0;
            wdt_reset_pulse <= 1'b0;
            apb(1'b0, OFS_CLKCTRL, 32'h0);
            `CHK("hard", {q[20:16], q[11:9], q[8:6]}, 11'h7A1)
        end
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CLKCTRL, 32'h0);
        `CHK("por_xtal", q[19], 1'b0)
    endtask
    // Main sequence: oscillators tick and report ready; no low-power entry
    initial begin
        {presetn, sys_reset_pulse, wdt_reset_pulse, psel, penable, pwrite} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        osc_tick = 5'h1F;
        osc_ready_in = 5'h1F;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_div();
        t_switch();
        t_cal();
        t_hard();
        give_verdict();
    end
endmodule // system_clock_switch_and_prescaler_tb_top
bind scs_clock_switch scs_asserts u_chk (.pclk, .presetn, .sys_reset_pulse, .wdt_reset_pulse,
    .psel, .penable, .paddr, .pslverr, .osc_tick, .osc_enable, .root_core_clock, .hclk_tick,
    .pclk_tick, .always_on_domain_clock, .uart_baud_tick);
`default_nettype wire

/* verilog/scs_autocal.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_autocal
    import scs_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Reference and oscillator ticks
    input  wire logic              ipo_tick,
    input  wire logic              ertco_tick,
    // Control
    input  wire logic              cal_en,
    input  wire logic              cal_load,
    input  wire logic [TRIM_W-1:0] init_trim,
    input  wire logic [CDIV_W-1:0] div_val,
    input  wire logic [RUN_W-1:0]  runtime,
    input  wire logic [GAIN_W-1:0] gain,
    // Result
    output logic      [TRIM_W-1:0] trim
);
    localparam logic [TRIM_W:0] TRIM_MAX = {1'b0, {TRIM_W{1'b1}}};

    logic [CDIV_W-1:0] pre_r,  pre_nxt;
    logic [RUN_W:0]    hits_r, hits_nxt;
    logic [RUN_W-1:0]  win_r,  win_nxt;
    logic [TRIM_W-1:0] trim_r, trim_nxt;
    logic              pulse;
    logic [TRIM_W:0]   up;

    // Divide the fast oscillator toward the crystal rate, count against crystal windows
    always_comb begin
        pre_nxt  = pre_r;
        hits_nxt = hits_r;
        win_nxt  = win_r;
        trim_nxt = trim_r;
        pulse    = 1'b0;
        up       = {1'b0, trim_r} + {{(TRIM_W+1-GAIN_W){1'b0}}, gain};
        if (cal_load) begin
            trim_nxt = init_trim;
            pre_nxt  = '0;
            hits_nxt = '0;
            win_nxt  = '0;
        end else if (cal_en) begin
            if (ipo_tick) begin
                if (pre_r >= div_val - 13'h0001) begin
                    pre_nxt = '0;
                    pulse   = 1'b1;
                end else begin
                    pre_nxt = pre_r + 13'h0001;
                end
            end
            // Saturate so a wildly fast oscillator cannot wrap the comparison
            if (pulse && hits_r != {(RUN_W+1){1'b1}}) begin
                hits_nxt = hits_r + 9'h001;
            end
            if (ertco_tick) begin
                if (win_r >= runtime - 8'h01) begin
                    win_nxt  = '0;
                    // A pulse on the closing tick opens the next window instead of being lost
                    hits_nxt = {{RUN_W{1'b0}}, pulse};
                    // Fast oscillator steps trim down, slow one steps it up
                    if (hits_r > {1'b0, runtime}) begin
                        trim_nxt = (trim_r > {{(TRIM_W-GAIN_W){1'b0}}, gain}) ?
                                   trim_r - {{(TRIM_W-GAIN_W){1'b0}}, gain} : '0;
                    end else if (hits_r < {1'b0, runtime}) begin
                        trim_nxt = (up > TRIM_MAX) ? TRIM_MAX[TRIM_W-1:0] : up[TRIM_W-1:0];
                    end
                end else begin
                    win_nxt = win_r + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r  <= '0;
            hits_r <= '0;
            win_r  <= '0;
            trim_r <= TRIM_RST;
        end else begin
            pre_r  <= pre_nxt;
            hits_r <= hits_nxt;
            win_r  <= win_nxt;
            trim_r <= trim_nxt;
        end
    end

    assign trim = trim_r;
endmodule : scs_autocal
`default_nettype wire

/* verilog/scs_clock_switch.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_switch
    import scs_pkg::*;
#(
    parameter logic [SEL_W-1:0] DEFAULT_SEL     = SEL_IPO,
    parameter logic             IPO_EN_DEFAULT  = 1'b1,
    parameter logic             IBRO_EN_DEFAULT = 1'b1
) (
    // Clock and power-on reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Hard reset requests, one-cycle pulses on pclk
    input  wire logic              sys_reset_pulse,
    input  wire logic              wdt_reset_pulse,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Oscillators: ticks on pclk, ready levels from analog
    input  wire logic [NOSC-1:0]   osc_tick,
    input  wire logic [NOSC-1:0]   osc_ready_in,
    output logic      [NOSC-1:0]   osc_enable,
    output logic      [TRIM_W-1:0] ipo_trim,
    output logic                   baud_osc_supply_select,
    // Derived clock ticks
    output logic                   root_core_clock,
    output logic                   hclk_tick,
    output logic                   pclk_tick,
    output logic                   always_on_domain_clock,
    output logic                   uart_baud_tick
);
    if (NOSC != 5 || !(DEFAULT_SEL inside {SEL_ERFO, SEL_INRO, SEL_IPO, SEL_IBRO, SEL_ERTCO}))
    begin : g_bad_cfg
        $error("scs_clock_switch: unsupported default source");
    end

    // Map a select code to an oscillator index; invalid codes never switch
    function automatic logic [3:0] sel_to_osc(input logic [SEL_W-1:0] s);
        unique case (s)
            SEL_IPO:   sel_to_osc = {1'b1, 3'(OSC_IPO)};
            SEL_ERFO:  sel_to_osc = {1'b1, 3'(OSC_ERFO)};
            SEL_ERTCO: sel_to_osc = {1'b1, 3'(OSC_ERTCO)};
            SEL_INRO:  sel_to_osc = {1'b1, 3'(OSC_INRO)};
            SEL_IBRO:  sel_to_osc = {1'b1, 3'(OSC_IBRO)};
            default:   sel_to_osc = 4'h0;
        endcase
    endfunction

    // Power-on enable pattern; INRO forced on, ERTCO and ERFO off
    localparam logic [NOSC-1:0] EN_RST = NOSC'((1 << OSC_INRO)
                                         | (int'(IPO_EN_DEFAULT) << OSC_IPO)
                                         | (int'(IBRO_EN_DEFAULT) << OSC_IBRO));
    localparam logic [2:0] DEF_OSC = 3'(sel_to_osc(DEFAULT_SEL));

    // Register state
    logic [NOSC-1:0]   en_r,      en_nxt;
    logic [SEL_W-1:0]  sel_r,     sel_nxt;
    logic [DIV_W-1:0]  div_r,     div_nxt;
    logic              vs_r,      vs_nxt;
    logic [AON_W-1:0]  aon_r,     aon_nxt;
    logic              csel_r,    csel_nxt;
    logic              cen_r,     cen_nxt;
    logic              cload_r,   cload_nxt;
    logic [GAIN_W-1:0] gain_r,    gain_nxt;
    logic [TRIM_W-1:0] init_r,    init_nxt;
    logic [CDIV_W-1:0] cdiv_r,    cdiv_nxt;
    logic [RUN_W-1:0]  run_r,     run_nxt;
    logic [31:0]       rdata_r,   rdata_nxt;
    // Switch and divider state
    scs_sw_e           sw_r,      sw_nxt;
    logic [2:0]        act_r,     act_nxt;
    logic [DIV_W-1:0]  adiv_r,    adiv_nxt;
    logic [6:0]        cnt_r,     cnt_nxt;
    logic              ph_r,      ph_nxt;
    logic [4:0]        aod_r,     aod_nxt;
    logic              root_r,    root_nxt;
    logic              pck_r,     pck_nxt;
    logic              aodck_r,   aodck_nxt;
    logic              baud_r,    baud_nxt;
    // Ready synchronisers
    logic [NOSC-1:0]   s1_r, s2_r, s3_r, rdy_r, rdy_nxt;

    logic              wr, rd_setup, hard, mapped, boundary, src_tick, tgt_ok;
    logic [3:0]        tgt;
    logic [NOSC-1:0]   ok;
    logic [TRIM_W-1:0] cal_trim;
    logic [31:0]       rd_val;

    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign hard     = sys_reset_pulse || wdt_reset_pulse;
    assign mapped   = paddr inside {OFS_CLKCTRL, OFS_BUSDIV, OFS_CALCTRL,
                                    OFS_CALINIT, OFS_CALTIMING};
    assign ok       = en_r & rdy_r;
    assign tgt      = sel_to_osc(sel_r);
    assign tgt_ok   = tgt[3] && ok[tgt[2:0]];
    assign src_tick = osc_tick[act_r] && ok[act_r];
    assign boundary = src_tick && (cnt_r == 7'((1 << adiv_r) - 1));

    // Read mux
    always_comb begin
        rd_val = '0;
        unique case (paddr)
            OFS_CLKCTRL: begin
                rd_val[CC_DIV_LSB +: DIV_W] = div_r;
                rd_val[CC_SEL_LSB +: SEL_W] = sel_r;
                rd_val[CC_RDY_BIT]          = (sw_r == SCS_SW_IDLE);
                rd_val[CC_EN_LSB +: NOSC]   = en_r;
                rd_val[CC_VS_BIT]           = vs_r;
                rd_val[CC_OK_LSB +: NOSC]   = ok;
            end
            OFS_BUSDIV:  rd_val[AON_W-1:0] = aon_r;
            OFS_CALCTRL: begin
                rd_val[CAL_SEL_BIT]              = csel_r;
                rd_val[CAL_EN_BIT]               = cen_r;
                rd_val[CAL_GAIN_LSB +: GAIN_W]   = gain_r;
                rd_val[CAL_TRIM_LSB +: TRIM_W]   = cal_trim;
            end
            OFS_CALINIT:   rd_val[TRIM_W-1:0] = init_r;
            OFS_CALTIMING: begin
                rd_val[CDIV_W-1:0]            = cdiv_r;
                rd_val[CT_RUN_LSB +: RUN_W]   = run_r;
            end
            default: rd_val = '0;
        endcase
    end

    // Register file next state; hard reset beats a same-cycle write to enables, select and divider
    always_comb begin
        en_nxt    = en_r;
        sel_nxt   = sel_r;
        div_nxt   = div_r;
        vs_nxt    = vs_r;
        aon_nxt   = aon_r;
        csel_nxt  = csel_r;
        cen_nxt   = cen_r;
        cload_nxt = 1'b0;
        gain_nxt  = gain_r;
        init_nxt  = init_r;
        cdiv_nxt  = cdiv_r;
        run_nxt   = run_r;
        rdata_nxt = rd_setup ? rd_val : rdata_r;
        if (wr) begin
            unique case (paddr)
                OFS_CLKCTRL: begin
                    en_nxt  = pwdata[CC_EN_LSB +: NOSC] | NOSC'(1 << OSC_INRO);
                    sel_nxt = pwdata[CC_SEL_LSB +: SEL_W];
                    div_nxt = pwdata[CC_DIV_LSB +: DIV_W];
                    vs_nxt  = pwdata[CC_VS_BIT];
                end
                OFS_BUSDIV:  aon_nxt = pwdata[AON_W-1:0];
                OFS_CALCTRL: begin
                    csel_nxt  = pwdata[CAL_SEL_BIT];
                    cen_nxt   = pwdata[CAL_EN_BIT];
                    cload_nxt = pwdata[CAL_LOAD_BIT]; // Self-clearing strobe
                    gain_nxt  = pwdata[CAL_GAIN_LSB +: GAIN_W];
                end
                OFS_CALINIT:   init_nxt = pwdata[TRIM_W-1:0];
                OFS_CALTIMING: begin
                    cdiv_nxt = pwdata[CDIV_W-1:0];
                    run_nxt  = pwdata[CT_RUN_LSB +: RUN_W];
                end
                default: ;
            endcase
        end
        if (hard) begin
            // Watch crystal enable survives; other enables, select and divider back to power-on value
            en_nxt  = (EN_RST & ~NOSC'(1 << OSC_ERTCO)) | (en_r & NOSC'(1 << OSC_ERTCO));
            sel_nxt = DEFAULT_SEL;
            div_nxt = DIV_RST;
        end
    end

    // Switchover and divider: changes land when a full output period ends or the active source is not ok
    always_comb begin
        sw_nxt   = sw_r;
        act_nxt  = act_r;
        adiv_nxt = adiv_r;
        cnt_nxt  = cnt_r;
        ph_nxt   = ph_r;
        aod_nxt  = aod_r;
        root_nxt = boundary;
        pck_nxt  = boundary && ph_r;
        aodck_nxt = 1'b0;
        baud_nxt = osc_tick[OSC_IBRO] && ok[OSC_IBRO];
        if (sel_nxt != sel_r) begin
            sw_nxt = SCS_SW_WAIT;
        end
        if (src_tick) begin
            cnt_nxt = boundary ? 7'h00 : cnt_r + 7'h01;
        end
        if (boundary || !ok[act_r]) begin
            adiv_nxt = div_r;
            if (!boundary) begin
                cnt_nxt = 7'h00;
            end
            if (sw_r == SCS_SW_WAIT && sel_nxt == sel_r && tgt_ok) begin
                act_nxt = tgt[2:0];
                cnt_nxt = 7'h00;
                sw_nxt  = SCS_SW_IDLE;
            end
        end
        if (boundary) begin
            ph_nxt = ~ph_r;
            if (ph_r) begin
                if (aod_r == 5'((AOD_BASE << aon_r) - 5'h01)) begin
                    aod_nxt   = 5'h00;
                    aodck_nxt = 1'b1;
                end else begin
                    aod_nxt = aod_r + 5'h01;
                end
            end
        end
    end

    // Ready filter: accept a new level once the last two stages agree
    always_comb begin
        rdy_nxt = rdy_r;
        for (int i = 0; i < NOSC; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                rdy_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r    <= EN_RST;
            sel_r   <= DEFAULT_SEL;
            div_r   <= DIV_RST;
            vs_r    <= 1'b0;
            aon_r   <= AON_RST;
            csel_r  <= 1'b0;
            cen_r   <= 1'b0;
            cload_r <= 1'b0;
            gain_r  <= GAIN_RST;
            init_r  <= TRIM_RST;
            cdiv_r  <= CDIV_RST;
            run_r   <= RUN_RST;
            rdata_r <= '0;
            sw_r    <= SCS_SW_WAIT;
            act_r   <= DEF_OSC;
            adiv_r  <= DIV_RST;
            cnt_r   <= '0;
            ph_r    <= 1'b0;
            aod_r   <= '0;
            root_r  <= 1'b0;
            pck_r   <= 1'b0;
            aodck_r <= 1'b0;
            baud_r  <= 1'b0;
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            rdy_r   <= '0;
        end else begin
            en_r    <= en_nxt;
            sel_r   <= sel_nxt;
            div_r   <= div_nxt;
            vs_r    <= vs_nxt;
            aon_r   <= aon_nxt;
            csel_r  <= csel_nxt;
            cen_r   <= cen_nxt;
            cload_r <= cload_nxt;
            gain_r  <= gain_nxt;
            init_r  <= init_nxt;
            cdiv_r  <= cdiv_nxt;
            run_r   <= run_nxt;
            rdata_r <= rdata_nxt;
            sw_r    <= sw_nxt;
            act_r   <= act_nxt;
            adiv_r  <= adiv_nxt;
            cnt_r   <= cnt_nxt;
            ph_r    <= ph_nxt;
            aod_r   <= aod_nxt;
            root_r  <= root_nxt;
            pck_r   <= pck_nxt;
            aodck_r <= aodck_nxt;
            baud_r  <= baud_nxt;
            s1_r    <= osc_ready_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            rdy_r   <= rdy_nxt;
        end
    end

    // Trim search loop
    scs_autocal u_autocal (
        .pclk       (pclk),
        .presetn    (presetn),
        .ipo_tick   (osc_tick[OSC_IPO] && ok[OSC_IPO]),
        .ertco_tick (osc_tick[OSC_ERTCO] && ok[OSC_ERTCO]),
        .cal_en     (cen_r),
        .cal_load   (cload_r),
        .init_trim  (init_r),
        .div_val    (cdiv_r),
        .runtime    (run_r),
        .gain       (gain_r),
        .trim       (cal_trim)
    );

    // Outputs; trim falls back to the loaded start value when select is off
    assign ipo_trim               = csel_r ? cal_trim : init_r;
    assign osc_enable             = en_r;
    assign baud_osc_supply_select = vs_r;
    assign root_core_clock        = root_r;
    assign hclk_tick              = root_r;
    assign pclk_tick              = pck_r;
    assign always_on_domain_clock = aodck_r;
    assign uart_baud_tick         = baud_r;
    assign prdata                 = rdata_r;
    assign pready                 = 1'b1;
    assign pslverr                = psel && penable && !mapped;
endmodule : scs_clock_switch
`default_nettype wire

/* verilog/scs_pkg.sv */
`default_nettype none
package scs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CLKCTRL   = 8'h00;
    localparam logic [7:0] OFS_BUSDIV    = 8'h04;
    localparam logic [7:0] OFS_CALCTRL   = 8'h08;
    localparam logic [7:0] OFS_CALINIT   = 8'h0C;
    localparam logic [7:0] OFS_CALTIMING = 8'h10;

    // clock_control_register field positions
    localparam int CC_DIV_LSB   = 6;
    localparam int CC_SEL_LSB   = 9;
    localparam int CC_RDY_BIT   = 13;
    localparam int CC_EN_LSB    = 16;
    localparam int CC_VS_BIT    = 21;
    localparam int CC_OK_LSB    = 24;

    // calibration_control field positions
    localparam int CAL_SEL_BIT  = 0;
    localparam int CAL_EN_BIT   = 1;
    localparam int CAL_LOAD_BIT = 2;
    localparam int CAL_GAIN_LSB = 4;
    localparam int CAL_TRIM_LSB = 16;
    // calibration_timing field positions
    localparam int CT_RUN_LSB   = 16;

    // Field widths
    localparam int DIV_W  = 3;
    localparam int SEL_W  = 3;
    localparam int AON_W  = 2;
    localparam int TRIM_W = 9;
    localparam int CDIV_W = 13;
    localparam int RUN_W  = 8;
    localparam int GAIN_W = 4;
    localparam int NOSC   = 5;

    // Oscillator indices into enable, ready and tick vectors
    localparam int OSC_ERFO  = 0;
    localparam int OSC_IPO   = 1;
    localparam int OSC_IBRO  = 2;
    localparam int OSC_ERTCO = 3;
    localparam int OSC_INRO  = 4;

    // Source-select encodings
    localparam logic [SEL_W-1:0] SEL_ERFO  = 3'h2;
    localparam logic [SEL_W-1:0] SEL_INRO  = 3'h3;
    localparam logic [SEL_W-1:0] SEL_IPO   = 3'h4;
    localparam logic [SEL_W-1:0] SEL_IBRO  = 3'h5;
    localparam logic [SEL_W-1:0] SEL_ERTCO = 3'h6;

    // Reset values
    localparam logic [DIV_W-1:0]  DIV_RST    = 3'h1;
    localparam logic [AON_W-1:0]  AON_RST    = 2'h0;
    localparam logic [TRIM_W-1:0] TRIM_RST   = 9'h100;
    localparam logic [CDIV_W-1:0] CDIV_RST   = 13'h0BEB;
    localparam logic [RUN_W-1:0]  RUN_RST    = 8'h0A;
    localparam logic [GAIN_W-1:0] GAIN_RST   = 4'h4;
    localparam logic [4:0]        AOD_BASE   = 5'h04;

    typedef enum logic [0:0] {
        SCS_SW_IDLE = 1'b0,
        SCS_SW_WAIT = 1'b1
    } scs_sw_e;
endpackage : scs_pkg
`default_nettype wire
